// file: logic/crossbar_pkg.sv
// constants, register map and signal ids of the port crossbar
package crossbar_pkg;
  localparam int NPORTS   = 8;
  localparam int NPINS    = 64;
  localparam int XPINS    = 23;
  localparam int NUM_SIG  = 19;
  localparam int DBG_PIN  = 56;
  typedef logic [4:0] sig_id_t;
  // peripheral signals in priority order
  localparam int SIG_UART_TX  = 0;
  localparam int SIG_UART_RX  = 1;
  localparam int SIG_SPIB_SCK = 2;
  localparam int SIG_SPIB_NSS = 5;
  localparam int SIG_SPIA_SCK = 6;
  localparam int SIG_SPIA_NSS = 9;
  localparam int SIG_SDA      = 10;
  localparam int SIG_SCL      = 11;
  localparam int SIG_SYSCLK   = 12;
  localparam int SIG_CEX0     = 13;
  localparam int NUM_CEX      = 6;
  // fixed pins
  localparam int PIN_UART_TX  = 4;
  localparam int PIN_UART_RX  = 5;
  localparam int PIN_SPIB_SCK = 16;
  // select bits
  localparam int SEL_A_UART   = 0;
  localparam int SEL_A_SPIA   = 1;
  localparam int SEL_A_SMB    = 2;
  localparam int SEL_A_SYSCLK = 3;
  localparam int SEL_C_SPIB   = 0;
  localparam int SEL_C_ENABLE = 6;
  // reset values
  localparam logic [7:0] LATCH_RST = 8'hFF;
  localparam logic [7:0] CFG_RST   = 8'h00;
  // register addresses
  localparam logic [7:0] LATCH_ADDR [NPORTS] =
    '{8'h80, 8'h90, 8'hA0, 8'hB0, 8'hD9, 8'hDA, 8'hDB, 8'hDC};
  localparam logic [7:0] DRIVE_ADDR [NPORTS] =
    '{8'hA4, 8'hA5, 8'hA6, 8'hA7, 8'hA2, 8'hA3, 8'hA1, 8'h9F};
  localparam logic [7:0] MODE_ADDR  [NPORTS] =
    '{8'hA8, 8'hA9, 8'hAA, 8'hAB, 8'hAC, 8'hAD, 8'hAE, 8'hAF};
  localparam logic [7:0] ANALOG_ADDR [NPORTS] =
    '{8'hB8, 8'hB9, 8'hBA, 8'hBB, 8'hBC, 8'hBD, 8'hBE, 8'hBF};
  localparam logic [7:0] SKIP_ADDR [3] = '{8'hD4, 8'hD5, 8'hD6};
  localparam logic [7:0] SEL_ADDR  [3] = '{8'hE1, 8'hE2, 8'hE3};
endpackage

// file: logic/pin_allocator.sv
// priority allocation of peripheral signals to crossbar pins
`timescale 1ns/10ps
module pin_allocator
  import crossbar_pkg::*;
(
  // selection and skip state
  input  wire logic [7:0]       sel_a_i,
  input  wire logic [7:0]       sel_b_i,
  input  wire logic [7:0]       sel_c_i,
  input  wire logic [XPINS-1:0] skip_i,
  input  wire logic             spia_four_wire_i,
  input  wire logic             spib_four_wire_i,
  // ownership per pin
  output logic [XPINS-1:0]      own_vld_o,
  output sig_id_t               own_id_o [XPINS]
);
  always_comb begin
    logic [NUM_SIG-1:0] want;
    logic [XPINS-1:0]   taken;
    logic               found;
    want      = '0;
    taken     = '0;
    found     = 1'b0;
    own_vld_o = '0;
    for (int p = 0; p < XPINS; p++) begin
      own_id_o[p] = '0;
    end
    want[SIG_UART_TX] = sel_a_i[SEL_A_UART];
    want[SIG_UART_RX] = sel_a_i[SEL_A_UART];
    for (int s = SIG_SPIB_SCK; s < SIG_SPIB_NSS; s++) begin
      want[s] = sel_c_i[SEL_C_SPIB];
    end
    want[SIG_SPIB_NSS] = sel_c_i[SEL_C_SPIB] & spib_four_wire_i;
    for (int s = SIG_SPIA_SCK; s < SIG_SPIA_NSS; s++) begin
      want[s] = sel_a_i[SEL_A_SPIA];
    end
    want[SIG_SPIA_NSS] = sel_a_i[SEL_A_SPIA] & spia_four_wire_i;
    want[SIG_SDA]      = sel_a_i[SEL_A_SMB];
    want[SIG_SCL]      = sel_a_i[SEL_A_SMB];
    want[SIG_SYSCLK]   = sel_a_i[SEL_A_SYSCLK];
    for (int k = 0; k < NUM_CEX; k++) begin
      want[SIG_CEX0 + k] = 3'(k) < sel_b_i[2:0];
    end
    // fixed placements come first
    for (int s = SIG_UART_TX; s <= SIG_UART_RX; s++) begin
      if (want[s]) begin
        own_vld_o[PIN_UART_TX + s] = 1'b1;
        own_id_o[PIN_UART_TX + s]  = sig_id_t'(s);
        taken[PIN_UART_TX + s]     = 1'b1;
      end
    end
    for (int s = SIG_SPIB_SCK; s <= SIG_SPIB_NSS; s++) begin
      if (want[s]) begin
        own_vld_o[PIN_SPIB_SCK + s - SIG_SPIB_SCK] = 1'b1;
        own_id_o[PIN_SPIB_SCK + s - SIG_SPIB_SCK]  = sig_id_t'(s);
        taken[PIN_SPIB_SCK + s - SIG_SPIB_SCK]     = 1'b1;
      end
    end
    // the rest take the lowest free unskipped pin
    for (int s = SIG_SPIA_SCK; s < NUM_SIG; s++) begin
      found = 1'b0;
      for (int p = 0; p < XPINS; p++) begin
        if (want[s] && !found && !taken[p] && !skip_i[p]) begin
          own_vld_o[p] = 1'b1;
          own_id_o[p]  = sig_id_t'(s);
          taken[p]     = 1'b1;
          found        = 1'b1;
        end
      end
    end
  end
endmodule

// file: logic/priority_pin_crossbar.sv
// port data, configuration registers and pin crossbar
`timescale 1ns/10ps
module priority_pin_crossbar
  import crossbar_pkg::*;
#(
  parameter int NUM_PINS = 57
) (
  // clock and reset
  input  wire logic               REF_CLK_I,
  input  wire logic               RESET_I,
  // special function register port
  input  wire logic [7:0]         SFR_ADDR_I,
  input  wire logic               SFR_WR_I,
  input  wire logic               SFR_RD_I,
  input  wire logic [7:0]         SFR_WDATA_I,
  output logic      [7:0]         SFR_RDATA_O,
  // peripheral side
  input  wire logic [NUM_SIG-1:0] PERIPH_OUT_I,
  input  wire logic [NUM_SIG-1:0] PERIPH_OE_I,
  input  wire logic               SPIA_FOUR_WIRE_I,
  input  wire logic               SPIB_FOUR_WIRE_I,
  output logic      [NUM_SIG-1:0] PERIPH_IN_O,
  // debug data sharing P7.0
  input  wire logic               DBG_ACTIVE_I,
  input  wire logic               DBG_OUT_I,
  input  wire logic               DBG_OE_I,
  // pins
  input  wire logic [NPINS-1:0]   PIN_IN_I,
  output logic      [NPINS-1:0]   PIN_OUT_O,
  output logic      [NPINS-1:0]   PIN_OE_O,
  output logic      [NPINS-1:0]   PIN_DRIVE_HIGH_O,
  output logic      [NPINS-1:0]   PIN_ANALOG_O
);
  if (NUM_PINS < DBG_PIN + 1 || NUM_PINS > NPINS) begin : g_chk
    $error("NUM_PINS out of range");
  end

  logic [7:0]       latch_q  [NPORTS];
  logic [7:0]       latch_d  [NPORTS];
  logic [7:0]       drive_q  [NPORTS];
  logic [7:0]       drive_d  [NPORTS];
  logic [7:0]       mode_q   [NPORTS];
  logic [7:0]       mode_d   [NPORTS];
  logic [7:0]       analog_q [NPORTS];
  logic [7:0]       analog_d [NPORTS];
  logic [7:0]       skip_q   [3];
  logic [7:0]       skip_d   [3];
  logic [7:0]       sel_q    [3];
  logic [7:0]       sel_d    [3];
  logic [7:0]       rdata_d;
  logic [XPINS-1:0] own_vld;
  sig_id_t          own_id   [XPINS];
  logic [NPINS-1:0] out_d;
  logic [NPINS-1:0] oe_d;
  logic [NPINS-1:0] drv_d;
  logic [NPINS-1:0] ana_d;
  logic [NUM_SIG-1:0] pin_in_d;
  logic [NPINS-1:0] smb_d;
  logic [NPINS-1:0] smb_q;
  logic             xbar_en;
  logic             nss_routed;

  assign xbar_en = sel_q[2][SEL_C_ENABLE];

  pin_allocator u_alloc (
    .sel_a_i          (sel_q[0]),
    .sel_b_i          (sel_q[1]),
    .sel_c_i          (sel_q[2]),
    .skip_i           ({skip_q[2][6:0], skip_q[1], skip_q[0]}),
    .spia_four_wire_i (SPIA_FOUR_WIRE_I),
    .spib_four_wire_i (SPIB_FOUR_WIRE_I),
    .own_vld_o        (own_vld),
    .own_id_o         (own_id)
  );

  // register writes and reads
  always_comb begin
    latch_d  = latch_q;
    drive_d  = drive_q;
    mode_d   = mode_q;
    analog_d = analog_q;
    skip_d   = skip_q;
    sel_d    = sel_q;
    rdata_d  = 8'h00;
    for (int i = 0; i < NPORTS; i++) begin
      if (SFR_WR_I && SFR_ADDR_I == LATCH_ADDR[i]) begin
        latch_d[i] = SFR_WDATA_I;
      end
      if (SFR_WR_I && SFR_ADDR_I == DRIVE_ADDR[i]) begin
        drive_d[i] = SFR_WDATA_I;
      end
      if (SFR_WR_I && SFR_ADDR_I == MODE_ADDR[i]) begin
        mode_d[i] = SFR_WDATA_I;
      end
      if (SFR_WR_I && SFR_ADDR_I == ANALOG_ADDR[i]) begin
        analog_d[i] = SFR_WDATA_I;
      end
      if (SFR_RD_I && SFR_ADDR_I == LATCH_ADDR[i]) begin
        rdata_d = PIN_IN_I[i*8 +: 8];
      end
      if (SFR_RD_I && SFR_ADDR_I == DRIVE_ADDR[i]) begin
        rdata_d = drive_q[i];
      end
      if (SFR_RD_I && SFR_ADDR_I == MODE_ADDR[i]) begin
        rdata_d = mode_q[i];
      end
      if (SFR_RD_I && SFR_ADDR_I == ANALOG_ADDR[i]) begin
        rdata_d = analog_q[i];
      end
    end
    for (int i = 0; i < 3; i++) begin
      if (SFR_WR_I && SFR_ADDR_I == SKIP_ADDR[i]) begin
        skip_d[i] = SFR_WDATA_I;
      end
      if (SFR_WR_I && SFR_ADDR_I == SEL_ADDR[i]) begin
        sel_d[i] = SFR_WDATA_I;
      end
      if (SFR_RD_I && SFR_ADDR_I == SKIP_ADDR[i]) begin
        rdata_d = skip_q[i];
      end
      if (SFR_RD_I && SFR_ADDR_I == SEL_ADDR[i]) begin
        rdata_d = sel_q[i];
      end
    end
  end

  // pin drive computation
  always_comb begin
    logic [4:0] s;
    s        = '0;
    out_d    = '0;
    oe_d     = '0;
    drv_d    = '0;
    ana_d    = '0;
    smb_d    = '0;
    pin_in_d = '1;
    for (int p = 0; p < NUM_PINS; p++) begin
      drv_d[p] = drive_q[p/8][p%8];
      ana_d[p] = analog_q[p/8][p%8];
      out_d[p] = latch_q[p/8][p%8];
      oe_d[p]  = mode_q[p/8][p%8] | ~latch_q[p/8][p%8];
      if (p < XPINS && own_vld[p]) begin
        s        = own_id[p];
        out_d[p] = PERIPH_OUT_I[s];
        pin_in_d[s] = PIN_IN_I[p];
        if (s == SIG_SDA || s == SIG_SCL) begin
          smb_d[p] = 1'b1;
          oe_d[p]  = PERIPH_OE_I[s] & ~PERIPH_OUT_I[s];
        end else begin
          oe_d[p]  = PERIPH_OE_I[s] &
                     (mode_q[p/8][p%8] | ~PERIPH_OUT_I[s]);
        end
      end
      if (p == DBG_PIN && DBG_ACTIVE_I) begin
        out_d[p] = DBG_OUT_I;
        oe_d[p]  = DBG_OE_I;
      end
      if ((ana_d[p] || !xbar_en) && !(p == DBG_PIN && DBG_ACTIVE_I)) begin
        oe_d[p] = 1'b0;
      end
    end
  end

  always_ff @(posedge REF_CLK_I) begin
    if (RESET_I) begin
      for (int i = 0; i < NPORTS; i++) begin
        latch_q[i]  <= LATCH_RST;
        drive_q[i]  <= CFG_RST;
        mode_q[i]   <= CFG_RST;
        analog_q[i] <= CFG_RST;
      end
      for (int i = 0; i < 3; i++) begin
        skip_q[i] <= CFG_RST;
        sel_q[i]  <= CFG_RST;
      end
      SFR_RDATA_O      <= 8'h00;
      PIN_OUT_O        <= '0;
      PIN_OE_O         <= '0;
      PIN_DRIVE_HIGH_O <= '0;
      PIN_ANALOG_O     <= '0;
      PERIPH_IN_O      <= '1;
      smb_q            <= '0;
    end else begin
      latch_q          <= latch_d;
      drive_q          <= drive_d;
      mode_q           <= mode_d;
      analog_q         <= analog_d;
      skip_q           <= skip_d;
      sel_q            <= sel_d;
      SFR_RDATA_O      <= rdata_d;
      PIN_OUT_O        <= out_d;
      PIN_OE_O         <= oe_d;
      PIN_DRIVE_HIGH_O <= drv_d;
      PIN_ANALOG_O     <= ana_d;
      PERIPH_IN_O      <= pin_in_d;
      smb_q            <= smb_d;
    end
  end

  // any pin carrying the first sync serial slave select
  always_comb begin
    nss_routed = 1'b0;
    for (int p = 0; p < XPINS; p++) begin
      if (own_vld[p] && own_id[p] == sig_id_t'(SIG_SPIA_NSS)) begin
        nss_routed = 1'b1;
      end
    end
  end

  // checks
  default clocking cb @(posedge REF_CLK_I); endclocking
  default disable iff (RESET_I);

  a_drivers_off_dis: assert property (
    !xbar_en && !DBG_ACTIVE_I |=> PIN_OE_O == '0)
    else $error("driver on while disabled");
  a_drive_write: assert property (
    SFR_WR_I && SFR_ADDR_I == DRIVE_ADDR[0]
    ##1 !RESET_I |=> PIN_DRIVE_HIGH_O[7:0] == $past(SFR_WDATA_I, 2))
    else $error("drive strength not applied");
  a_latch_reset: assert property (
    disable iff (1'b0) RESET_I
    |=> latch_q[1] == LATCH_RST && drive_q[0] == CFG_RST)
    else $error("bad reset value");
  a_pin_readback: assert property (
    SFR_RD_I && SFR_ADDR_I == LATCH_ADDR[1]
    |=> SFR_RDATA_O == $past(PIN_IN_I[15:8]))
    else $error("port read not pin state");
  a_uart_fixed: assert property (sel_q[0][SEL_A_UART] |->
    own_vld[PIN_UART_TX] && own_id[PIN_UART_RX] == sig_id_t'(SIG_UART_RX))
    else $error("uart not on fixed pins");
  a_spib_fixed: assert property (
    sel_q[2][SEL_C_SPIB] && SPIB_FOUR_WIRE_I
    |-> own_id[PIN_SPIB_SCK + 3] == sig_id_t'(SIG_SPIB_NSS))
    else $error("spi b nss misplaced");
  a_first_free: assert property (
    sel_q[0][1:0] == 2'b10 && skip_q[0][1:0] == 2'b10 |->
    own_vld[0] && own_id[0] == sig_id_t'(SIG_SPIA_SCK) && !own_vld[1])
    else $error("lowest free pin not used");
  a_smb_open_drain: assert property (
    ##1 (PIN_OE_O & PIN_OUT_O & smb_q) == '0)
    else $error("two-wire pin driven high");
  a_nss_three_wire: assert property (
    !SPIA_FOUR_WIRE_I |-> !nss_routed)
    else $error("nss routed in three-wire mode");
  a_debug_share: assert property (DBG_ACTIVE_I |=>
    PIN_OUT_O[DBG_PIN] == $past(DBG_OUT_I) &&
    PIN_OE_O[DBG_PIN] == $past(DBG_OE_I))
    else $error("debug data not on shared pin");
  a_gpio_latch: assert property (
    xbar_en && !own_vld[8] && mode_q[1][0] && !analog_q[1][0]
    |=> PIN_OE_O[8] && PIN_OUT_O[8] == $past(latch_q[1][0]))
    else $error("gpio pin not from latch");
  a_analog_off: assert property (analog_q[0][0] |=> !PIN_OE_O[0])
    else $error("analog pin driven");

  c_uart_on: cover property (xbar_en && sel_q[0][SEL_A_UART]);
  c_spia_4w: cover property (sel_q[0][SEL_A_SPIA] && SPIA_FOUR_WIRE_I);
  c_smb_low: cover property (smb_q != '0 ##1 (PIN_OE_O & smb_q) != '0);
  c_debug: cover property (DBG_ACTIVE_I ##1 PIN_OE_O[DBG_PIN]);
endmodule

// file: testbench/pin_board_model.sv
// board model: pull-ups and test drivers on the port pins
`timescale 1ns/10ps
module pin_board_model
  import crossbar_pkg::*;
(
  // crossbar drive
  input  wire logic [NPINS-1:0] pin_out_i,
  input  wire logic [NPINS-1:0] pin_oe_i,
  // board drivers that pull a pin low
  input  wire logic [NPINS-1:0] ext_low_i,
  // resolved pin level
  output logic      [NPINS-1:0] level_o
);
  // undriven pins float high through the pull-up
  always_comb begin
    for (int i = 0; i < NPINS; i++) begin
      if (pin_oe_i[i]) begin
        level_o[i] = pin_out_i[i];
      end else if (ext_low_i[i]) begin
        level_o[i] = 1'b0;
      end else begin
        level_o[i] = 1'b1;
      end
    end
  end
endmodule

// file: testbench/priority_pin_crossbar_tb.sv
// self-checking bench of the priority pin crossbar
`timescale 1ns/10ps
module priority_pin_crossbar_tb;
  import crossbar_pkg::*;
  typedef struct packed {
    logic [7:0] sel_a;
    logic [7:0] skip0;
    logic       four_a;
    logic [4:0] sig;
    logic [5:0] pin;
  } row_t;
  logic               clk;
  logic               rst;
  logic [7:0]         addr;
  logic               wr;
  logic               rd;
  logic [7:0]         wdata;
  logic [7:0]         rdata;
  logic [NUM_SIG-1:0] p_out;
  logic [NUM_SIG-1:0] p_oe;
  logic [NUM_SIG-1:0] p_in;
  logic               spia_4w;
  logic               spib_4w;
  logic               dbg_act;
  logic               dbg_out;
  logic               dbg_oe;
  logic [NPINS-1:0]   pin_lvl;
  logic [NPINS-1:0]   pin_out;
  logic [NPINS-1:0]   pin_oe;
  logic [NPINS-1:0]   drv_hi;
  logic [NPINS-1:0]   ana;
  logic [NPINS-1:0]   ext_low;
  int                 miscompares;
  int                 n_checks;
  row_t rows [11] = '{
    '{8'h02, 8'h02, 1'b0, 5'h07, 6'h02},
    '{8'h07, 8'h00, 1'b0, 5'h06, 6'h00},
    '{8'h07, 8'h00, 1'b0, 5'h0A, 6'h03},
    '{8'h07, 8'h00, 1'b1, 5'h09, 6'h03},
    '{8'h07, 8'h00, 1'b1, 5'h0A, 6'h06},
    '{8'h07, 8'h01, 1'b1, 5'h06, 6'h01},
    '{8'h07, 8'h01, 1'b1, 5'h0B, 6'h08},
    '{8'h0F, 8'h00, 1'b1, 5'h0C, 6'h08},
    '{8'h01, 8'h30, 1'b0, 5'h01, 6'h05},
    '{8'h07, 8'h00, 1'b1, 5'h02, 6'h10},
    '{8'h07, 8'h00, 1'b1, 5'h05, 6'h13}
  };

  priority_pin_crossbar #(.NUM_PINS(57)) priority_pin_crossbar_inst (
    .REF_CLK_I(clk), .RESET_I(rst), .SFR_ADDR_I(addr), .SFR_WR_I(wr),
    .SFR_RD_I(rd), .SFR_WDATA_I(wdata), .SFR_RDATA_O(rdata),
    .PERIPH_OUT_I(p_out), .PERIPH_OE_I(p_oe),
    .SPIA_FOUR_WIRE_I(spia_4w), .SPIB_FOUR_WIRE_I(spib_4w),
    .PERIPH_IN_O(p_in), .DBG_ACTIVE_I(dbg_act), .DBG_OUT_I(dbg_out),
    .DBG_OE_I(dbg_oe), .PIN_IN_I(pin_lvl), .PIN_OUT_O(pin_out),
    .PIN_OE_O(pin_oe), .PIN_DRIVE_HIGH_O(drv_hi), .PIN_ANALOG_O(ana));

  pin_board_model pin_board_model_inst (
    .pin_out_i(pin_out), .pin_oe_i(pin_oe), .ext_low_i(ext_low),
    .level_o(pin_lvl));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic tally_and_finish();
    if (miscompares == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [63:0] exp,
                     input logic [63:0] got);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic sfr_wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    addr = a;
    wdata = d;
    wr = 1'b1;
    @(negedge clk);
    wr = 1'b0;
  endtask

  task automatic sfr_rd(input logic [7:0] a, input logic [7:0] exp,
                        input string name);
    @(negedge clk);
    addr = a;
    rd = 1'b1;
    @(negedge clk);
    rd = 1'b0;
    chk(name, exp, rdata);
  endtask

  task automatic settle();
    repeat (3) @(negedge clk);
  endtask

  task automatic do_reset();
    rst = 1'b1;
    repeat (8) @(negedge clk);
    chk("oe_in_reset", 64'h0, pin_oe);
    rst = 1'b0;
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    tally_and_finish();
  end

  initial begin
    {addr, wr, rd, wdata, p_out, p_oe, spia_4w, spib_4w} = '0;
    {dbg_act, dbg_out, dbg_oe, ext_low} = '0;
    miscompares = 0;
    n_checks = 0;
    do_reset();
    spib_4w = 1'b1;
    sfr_wr(8'hE3, 8'h41);
    foreach (rows[i]) begin
      sfr_wr(8'hE1, rows[i].sel_a);
      sfr_wr(8'hD4, rows[i].skip0);
      spia_4w = rows[i].four_a;
      ext_low = '0;
      ext_low[rows[i].pin] = 1'b1;
      settle();
      chk("periph_in", 64'h0, p_in[rows[i].sig]);
    end
    ext_low = '0;
    ext_low[9] = 1'b1;
    sfr_wr(8'hE2, 8'h02);
    settle();
    chk("cex1_in", 64'h0, p_in[SIG_CEX0 + 1]);
    sfr_wr(8'hE2, 8'h00);
    ext_low = '0;
    sfr_wr(8'hE1, 8'h07);
    sfr_wr(8'hD4, 8'h00);
    sfr_wr(8'hA8, 8'hFF);
    p_oe[10] = 1'b1;
    p_out[10] = 1'b1;
    p_oe[0] = 1'b1;
    p_out[0] = 1'b1;
    settle();
    chk("sda_high_oe", 64'h0, pin_oe[6]);
    chk("uart_tx", 64'h3, {pin_oe[4], pin_out[4]});
    p_out[10] = 1'b0;
    settle();
    chk("sda_low", 64'h2, {pin_oe[6], pin_out[6]});
    sfr_wr(8'hE3, 8'h01);
    dbg_act = 1'b1;
    dbg_oe = 1'b1;
    settle();
    chk("oe_disabled", 64'h0100_0000_0000_0000, pin_oe);
    chk("dbg_out", 64'h0, pin_out[56]);
    {dbg_act, dbg_oe, p_oe} = '0;
    sfr_wr(8'hE1, 8'h00);
    sfr_wr(8'hE3, 8'h40);
    sfr_wr(8'hD5, 8'hFF);
    sfr_wr(8'hA9, 8'hFF);
    sfr_wr(8'h90, 8'h5A);
    sfr_wr(8'hDB, 8'h3C);
    sfr_wr(8'hDC, 8'h00);
    settle();
    chk("p1_oe", 64'hFF, pin_oe[15:8]);
    chk("p1_out", 64'h5A, pin_out[15:8]);
    sfr_rd(8'h90, 8'h5A, "p1_read");
    chk("p6_oe", 64'hC3, pin_oe[55:48]);
    sfr_rd(8'hDB, 8'h3C, "p6_read");
    chk("p7_oe", 64'h01, pin_oe[63:56]);
    sfr_wr(8'hB8, 8'h01);
    settle();
    chk("p0_analog", 64'h01, ana[7:0]);
    chk("analog_oe", 64'h0, pin_oe[0]);
    sfr_wr(8'hA4, 8'h0F);
    sfr_wr(8'hA3, 8'hA5);
    sfr_wr(8'h00, 8'h77);
    settle();
    chk("p0_drive", 64'h0F, drv_hi[7:0]);
    chk("p5_drive", 64'hA5, drv_hi[47:40]);
    sfr_rd(8'hA4, 8'h0F, "p0_drv_read");
    sfr_rd(8'hA3, 8'hA5, "p5_drv_read");
    sfr_rd(8'h00, 8'h00, "unmapped_read");
    do_reset();
    settle();
    chk("oe_after_reset", 64'h0, pin_oe);
    chk("latch_after_reset", 64'hFF, pin_out[15:8]);
    chk("analog_after_reset", 64'h0, ana);
    chk("drive_after_reset", 64'h0, drv_hi);
    chk("periph_in_reset", 64'h7_FFFF, p_in);
    sfr_rd(8'hA4, 8'h00, "p0_drv_reset");
    sfr_rd(8'hA3, 8'h00, "p5_drv_reset");
    sfr_rd(8'h90, 8'hFF, "p1_reset");
    sfr_rd(8'hDB, 8'hFF, "p6_reset");
    tally_and_finish();
  end
endmodule
